// *** verilog/astl_pkg.sv ***
// Constants and carrier types for the absolute scale and soft travel limit block
package astl_pkg;
  // ****************************************
  // Scale resolution
  // ****************************************
  localparam int POS_W = 22;
  localparam int ERR_W = 24;
  localparam int TOOTH_COUNTS = 32768;
  localparam int MOTOR_TEETH = 80;
  localparam logic [POS_W-1:0] REV_COUNTS = POS_W'(TOOTH_COUNTS * MOTOR_TEETH);
  localparam int DEG_UNITS = 36000;
  // Degree units = counts * 36000 / 2621440 = counts * 225 / 2^14
  localparam int DEG_SHIFT = 14;
  localparam logic [29:0] DEG_MUL = 30'(DEG_UNITS / (TOOTH_COUNTS * MOTOR_TEETH / (1 << DEG_SHIFT)));
  localparam int DEG_W = 16;

  // ****************************************
  // Reset values and alarm codes
  // ****************************************
  localparam logic [POS_W-1:0] HOME_OFFSET_RST = 22'h000000;
  localparam logic [POS_W-1:0] SOFT_LIMIT_RST = 22'h000000;
  localparam logic [7:0] ALARM_SOFT_TRAVEL = 8'hF2;
  localparam logic [7:0] ALARM_NONE = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OT_CLEAR,
    OT_FROM_PLUS,
    OT_FROM_MINUS
  } astl_ot_t;

  typedef struct packed {
    logic password_ok;
    logic set_zero_here;
    logic teach_plus;
    logic teach_minus;
    logic write_plus;
    logic write_minus;
  } astl_host_t;

  typedef struct packed {
    logic soft_travel_alarm;
    logic plus_limit_flag_out;
    logic minus_limit_flag_out;
    logic servo_lock;
  } astl_alarm_t;
endpackage

// *** verilog/astl_wrap.sv ***
// Modulo one revolution adder for scale positions
`timescale 1ns/1ps
module astl_wrap (
  // Operands
  input wire logic [astl_pkg::POS_W-1:0] base_i,
  input wire logic signed [astl_pkg::ERR_W-1:0] delta_i,
  // Result in 0 .. one revolution minus one
  output logic [astl_pkg::POS_W-1:0] wrap_o
);
  logic signed [astl_pkg::ERR_W:0] sum;
  logic signed [astl_pkg::ERR_W:0] rev;

  always_comb begin
    rev = (astl_pkg::ERR_W+1)'(astl_pkg::REV_COUNTS);
    sum = $signed({3'b000, base_i}) + (astl_pkg::ERR_W+1)'(delta_i);
    if (sum < 0) begin
      sum = sum + rev;
    end else if (sum >= rev) begin
      sum = sum - rev;
    end
    wrap_o = sum[astl_pkg::POS_W-1:0];
  end
endmodule

// *** verilog/astl_core.sv ***
// Position scale, home offset and soft travel limit logic
`timescale 1ns/1ps
module astl_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Sensor and servo loop
  input wire logic [astl_pkg::POS_W-1:0] raw_count_i,
  input wire logic signed [astl_pkg::ERR_W-1:0] pos_error_i,
  input wire logic servo_on_cmd_i,
  // Host configuration and commands
  input wire logic scale_sense_flip_i,
  input wire astl_pkg::astl_host_t host_i,
  input wire logic [astl_pkg::POS_W-1:0] limit_data_i,
  input wire logic home_offset_restore_i,
  input wire logic [astl_pkg::POS_W-1:0] home_offset_data_i,
  // Motion requests in user scale
  input wire logic move_up_req_i,
  input wire logic move_down_req_i,
  input wire logic [astl_pkg::POS_W-1:0] target_i,
  // Hardware limit inputs
  input wire logic hw_limit_plus_i,
  input wire logic hw_limit_minus_i,
  // Scale outputs
  output logic [astl_pkg::POS_W-1:0] user_pos_o,
  output logic [astl_pkg::POS_W-1:0] cmd_pos_o,
  output logic [astl_pkg::DEG_W-1:0] read_angle_position_o,
  output logic [astl_pkg::POS_W-1:0] feedback_pos_o,
  output logic [astl_pkg::POS_W-1:0] home_offset_o,
  output logic [astl_pkg::POS_W-1:0] soft_limit_plus_o,
  output logic [astl_pkg::POS_W-1:0] soft_limit_minus_o,
  // Motion permission
  output logic allow_cw_o,
  output logic allow_ccw_o,
  output logic motion_halt_o,
  output logic path_up_o,
  // Alarm status
  output astl_pkg::astl_alarm_t alarm_o,
  output logic [7:0] read_alarm_cmd_o
);
  // ****************************************
  // Position arithmetic
  // ****************************************
  logic [astl_pkg::POS_W-1:0] cmd_phys;
  logic [astl_pkg::POS_W-1:0] act_fwd;
  logic [astl_pkg::POS_W-1:0] act_rev;
  logic [astl_pkg::POS_W-1:0] cmd_fwd;
  logic [astl_pkg::POS_W-1:0] cmd_rev;
  logic [astl_pkg::POS_W-1:0] next_user_pos;
  logic [astl_pkg::POS_W-1:0] next_cmd_pos;
  logic [astl_pkg::POS_W-1:0] home_offset;
  logic [astl_pkg::POS_W-1:0] soft_limit_plus;
  logic [astl_pkg::POS_W-1:0] soft_limit_minus;
  logic [astl_pkg::POS_W-1:0] arc_len;
  logic [astl_pkg::POS_W-1:0] arc_depth;
  logic [astl_pkg::POS_W-1:0] to_minus;
  logic [astl_pkg::POS_W-1:0] dist_up;
  logic [astl_pkg::POS_W-1:0] dist_down;
  logic [astl_pkg::POS_W-1:0] up_to_plus;
  logic [astl_pkg::POS_W-1:0] down_to_minus;
  logic [29:0] deg_prod;
  logic lim_en;
  logic in_arc;
  logic near_plus;
  logic short_up;
  logic up_cross;
  logic down_cross;
  logic next_path_up;
  logic power_up;
  astl_pkg::astl_ot_t ot_state;

  function automatic logic signed [astl_pkg::ERR_W-1:0] neg(
    input logic [astl_pkg::POS_W-1:0] v
  );
    neg = -$signed({2'b00, v});
  endfunction

  // Commanded position in physical CW counts
  astl_wrap u_cmd_phys (
    .base_i(raw_count_i),
    .delta_i(pos_error_i),
    .wrap_o(cmd_phys)
  );
  // Offset removed, both senses, wrapped
  astl_wrap u_act_fwd (.base_i(raw_count_i), .delta_i(neg(home_offset)), .wrap_o(act_fwd));
  astl_wrap u_act_rev (.base_i(home_offset), .delta_i(neg(raw_count_i)), .wrap_o(act_rev));
  astl_wrap u_cmd_fwd (.base_i(cmd_phys), .delta_i(neg(home_offset)), .wrap_o(cmd_fwd));
  astl_wrap u_cmd_rev (.base_i(home_offset), .delta_i(neg(cmd_phys)), .wrap_o(cmd_rev));
  // Arc geometry in user count-up sense
  astl_wrap u_arc_len (
    .base_i(soft_limit_minus),
    .delta_i(neg(soft_limit_plus)),
    .wrap_o(arc_len)
  );
  astl_wrap u_arc_depth (
    .base_i(cmd_pos_o),
    .delta_i(neg(soft_limit_plus)),
    .wrap_o(arc_depth)
  );
  astl_wrap u_to_minus (.base_i(arc_len), .delta_i(neg(arc_depth)), .wrap_o(to_minus));
  // Shortest path distances
  astl_wrap u_dist_up (.base_i(target_i), .delta_i(neg(cmd_pos_o)), .wrap_o(dist_up));
  astl_wrap u_dist_down (.base_i(cmd_pos_o), .delta_i(neg(target_i)), .wrap_o(dist_down));
  astl_wrap u_up_plus (
    .base_i(soft_limit_plus),
    .delta_i(neg(cmd_pos_o)),
    .wrap_o(up_to_plus)
  );
  astl_wrap u_down_minus (
    .base_i(cmd_pos_o),
    .delta_i(neg(soft_limit_minus)),
    .wrap_o(down_to_minus)
  );

  always_comb begin
    // Sense flag swaps count direction
    next_user_pos = scale_sense_flip_i ? act_rev : act_fwd;
    next_cmd_pos = scale_sense_flip_i ? cmd_rev : cmd_fwd;
    lim_en = (soft_limit_plus != soft_limit_minus);
    in_arc = lim_en && (arc_depth <= arc_len);
    near_plus = (arc_depth <= to_minus);
    short_up = (dist_up <= dist_down);
    up_cross = lim_en && (up_to_plus <= dist_up);
    down_cross = lim_en && (down_to_minus <= dist_down);
    next_path_up = short_up;
    // Turn the other way rather than cross the arc
    if (short_up && up_cross && !down_cross) begin
      next_path_up = 1'b0;
    end else if (!short_up && down_cross && !up_cross) begin
      next_path_up = 1'b1;
    end
    deg_prod = 30'(user_pos_o) * astl_pkg::DEG_MUL;
  end

  // ****************************************
  // Scale registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      user_pos_o <= '0;
      cmd_pos_o <= '0;
      feedback_pos_o <= '0;
      read_angle_position_o <= '0;
      path_up_o <= 1'b0;
    end else begin
      user_pos_o <= next_user_pos;
      cmd_pos_o <= next_cmd_pos;
      feedback_pos_o <= act_fwd;
      read_angle_position_o <= deg_prod[astl_pkg::DEG_SHIFT +: astl_pkg::DEG_W];
      path_up_o <= next_path_up;
    end
  end

  // ****************************************
  // Home offset
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      home_offset <= astl_pkg::HOME_OFFSET_RST;
    end else if (host_i.set_zero_here && host_i.password_ok) begin
      home_offset <= cmd_phys;
    end else if (home_offset_restore_i) begin
      home_offset <= home_offset_data_i;
    end
  end
  assign home_offset_o = home_offset;

  // ****************************************
  // Soft limit values
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      soft_limit_plus <= astl_pkg::SOFT_LIMIT_RST;
      soft_limit_minus <= astl_pkg::SOFT_LIMIT_RST;
    end else if (host_i.password_ok) begin
      if (host_i.teach_plus) begin
        soft_limit_plus <= user_pos_o;
      end else if (host_i.write_plus) begin
        soft_limit_plus <= limit_data_i;
      end
      if (host_i.teach_minus) begin
        soft_limit_minus <= user_pos_o;
      end else if (host_i.write_minus) begin
        soft_limit_minus <= limit_data_i;
      end
    end
  end
  assign soft_limit_plus_o = soft_limit_plus;
  assign soft_limit_minus_o = soft_limit_minus;

  // ****************************************
  // Overtravel state
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_up <= 1'b1;
    end else begin
      power_up <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ot_state <= astl_pkg::OT_CLEAR;
    end else begin
      case (ot_state)
        astl_pkg::OT_CLEAR: begin
          if (in_arc) begin
            ot_state <= near_plus ? astl_pkg::OT_FROM_PLUS : astl_pkg::OT_FROM_MINUS;
          end
        end
        astl_pkg::OT_FROM_PLUS, astl_pkg::OT_FROM_MINUS: begin
          if (!in_arc) begin
            ot_state <= astl_pkg::OT_CLEAR;
          end else if (power_up || !servo_on_cmd_i) begin
            ot_state <= near_plus ? astl_pkg::OT_FROM_PLUS : astl_pkg::OT_FROM_MINUS;
          end
        end
        default: begin
          ot_state <= astl_pkg::OT_CLEAR;
        end
      endcase
    end
  end

  // ****************************************
  // Motion permission and alarm outputs
  // ****************************************
  logic block_up;
  logic block_down;
  logic cw_soft_block;
  logic ccw_soft_block;

  always_comb begin
    block_up = (ot_state == astl_pkg::OT_FROM_PLUS);
    block_down = (ot_state == astl_pkg::OT_FROM_MINUS);
    cw_soft_block = scale_sense_flip_i ? block_down : block_up;
    ccw_soft_block = scale_sense_flip_i ? block_up : block_down;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      allow_cw_o <= 1'b0;
      allow_ccw_o <= 1'b0;
      motion_halt_o <= 1'b0;
    end else begin
      allow_cw_o <= !hw_limit_plus_i && !cw_soft_block;
      allow_ccw_o <= !hw_limit_minus_i && !ccw_soft_block;
      motion_halt_o <= (block_up && move_up_req_i) || (block_down && move_down_req_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alarm_o <= '0;
      read_alarm_cmd_o <= astl_pkg::ALARM_NONE;
    end else begin
      alarm_o.soft_travel_alarm <= (ot_state != astl_pkg::OT_CLEAR);
      alarm_o.plus_limit_flag_out <= (ot_state != astl_pkg::OT_CLEAR);
      alarm_o.minus_limit_flag_out <= (ot_state != astl_pkg::OT_CLEAR);
      alarm_o.servo_lock <= (ot_state != astl_pkg::OT_CLEAR) && servo_on_cmd_i;
      read_alarm_cmd_o <= (ot_state != astl_pkg::OT_CLEAR) ?
                          astl_pkg::ALARM_SOFT_TRAVEL : astl_pkg::ALARM_NONE;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_zero_takes_cmd: assert property (
    host_i.set_zero_here && host_i.password_ok |=> home_offset == $past(cmd_phys))
    else $error("zero-here did not capture commanded position");
  a_zero_needs_pw: assert property (
    !host_i.password_ok && !home_offset_restore_i |=> $stable(home_offset))
    else $error("home offset changed without password");
  a_limit_needs_pw: assert property (
    !host_i.password_ok |=> $stable(soft_limit_plus) && $stable(soft_limit_minus))
    else $error("soft limit changed without password");
  a_enter_alarm: assert property (
    ot_state == astl_pkg::OT_CLEAR && in_arc ##1 in_arc |=>
      alarm_o.soft_travel_alarm && read_alarm_cmd_o == astl_pkg::ALARM_SOFT_TRAVEL)
    else $error("arc entry did not raise alarm within two cycles");
  a_flags_follow: assert property (
    alarm_o.soft_travel_alarm |-> alarm_o.plus_limit_flag_out && alarm_o.minus_limit_flag_out)
    else $error("limit flags not both closed in overtravel");
  a_arc_disabled: assert property (
    soft_limit_plus == soft_limit_minus [*2] |=> ot_state == astl_pkg::OT_CLEAR)
    else $error("overtravel with equal limits");
  a_mid_plus: assert property (
    in_arc && arc_depth == to_minus && (ot_state == astl_pkg::OT_CLEAR || !servo_on_cmd_i)
      |=> ot_state == astl_pkg::OT_FROM_PLUS)
    else $error("midpoint entry not taken as plus side");
  a_hw_cw_block: assert property (
    hw_limit_plus_i |=> !allow_cw_o)
    else $error("plus hardware limit did not block CW");
  a_hw_ccw_block: assert property (
    hw_limit_minus_i |=> !allow_ccw_o)
    else $error("minus hardware limit did not block CCW");
  a_halt_toward: assert property (
    block_up && move_up_req_i |=> motion_halt_o)
    else $error("move toward arc not halted");
  a_path_avoid: assert property (
    short_up && up_cross && !down_cross |=> !path_up_o)
    else $error("shortest path crosses arc");
  a_pos_wrap: assert property (
    user_pos_o < astl_pkg::REV_COUNTS && cmd_pos_o < astl_pkg::REV_COUNTS)
    else $error("user position out of one revolution");

  c_enter_arc: cover property (ot_state == astl_pkg::OT_CLEAR ##1 ot_state != astl_pkg::OT_CLEAR);
  c_zero_here: cover property (host_i.set_zero_here && host_i.password_ok);
  c_path_turn: cover property (short_up && up_cross && !down_cross);
  c_leave_arc: cover property (ot_state != astl_pkg::OT_CLEAR ##1 ot_state == astl_pkg::OT_CLEAR);
endmodule

// *** verification/astl_sensor_model.sv ***
// Behavioural absolute sensor that feeds raw count and servo loop error
`timescale 1ns/1ps
module astl_sensor_model (
  // Clock
  input wire logic clk_i,
  // Physical shaft position and loop error
  input wire logic [21:0] phys_i,
  input wire logic signed [23:0] err_i,
  // Sensor outputs
  output logic [21:0] raw_count_o,
  output logic signed [23:0] pos_error_o
);
  localparam int REV = astl_pkg::TOOTH_COUNTS * astl_pkg::MOTOR_TEETH;

  // Count stays inside one revolution
  always_ff @(posedge clk_i) begin
    raw_count_o <= 22'(int'(phys_i) % REV);
    pos_error_o <= err_i;
  end
endmodule

// *** verification/astl_core_test.sv ***
// Self-checking bench for the scale and soft travel limit core
`timescale 1ns/1ps
module astl_core_test;
  localparam int REV = astl_pkg::TOOTH_COUNTS * astl_pkg::MOTOR_TEETH;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [21:0] phys = '0;
  logic signed [23:0] err = '0;
  logic [21:0] raw_count;
  logic signed [23:0] pos_error;
  logic servo_on = 1'b0;
  logic flip = 1'b0;
  astl_pkg::astl_host_t host = '0;
  logic [21:0] limit_data = '0;
  logic restore = 1'b0;
  logic [21:0] restore_data = '0;
  logic up_req = 1'b0;
  logic down_req = 1'b0;
  logic [21:0] target = '0;
  logic hw_plus = 1'b0;
  logic hw_minus = 1'b0;
  logic [21:0] user_pos, cmd_pos, fb_pos, offset, lim_p, lim_m;
  logic [15:0] deg;
  logic allow_cw, allow_ccw, halt, path_up;
  astl_pkg::astl_alarm_t alarm;
  logic [7:0] alarm_code;
  int num_errors = 0;
  int num_checks = 0;
  int r, e, off;
  logic [21:0] u;

  // ****************************************
  // Clock, partner and design
  // ****************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  astl_sensor_model i_sensor (.clk_i(clk_i), .phys_i(phys), .err_i(err),
    .raw_count_o(raw_count), .pos_error_o(pos_error));

  astl_core i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .raw_count_i(raw_count),
    .pos_error_i(pos_error), .servo_on_cmd_i(servo_on), .scale_sense_flip_i(flip),
    .host_i(host), .limit_data_i(limit_data), .home_offset_restore_i(restore),
    .home_offset_data_i(restore_data), .move_up_req_i(up_req), .move_down_req_i(down_req),
    .target_i(target), .hw_limit_plus_i(hw_plus), .hw_limit_minus_i(hw_minus),
    .user_pos_o(user_pos), .cmd_pos_o(cmd_pos), .read_angle_position_o(deg),
    .feedback_pos_o(fb_pos), .home_offset_o(offset), .soft_limit_plus_o(lim_p),
    .soft_limit_minus_o(lim_m), .allow_cw_o(allow_cw), .allow_ccw_o(allow_ccw),
    .motion_halt_o(halt), .path_up_o(path_up), .alarm_o(alarm),
    .read_alarm_cmd_o(alarm_code));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [21:0] exp_user(input int p, input int o, input logic f);
    int d;
    d = (p + REV - o) % REV;
    if (f) begin
      d = (REV - d) % REV;
    end
    return 22'(d);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic put(input int p, input int ev);
    @(posedge clk_i);
    phys <= 22'(p);
    err <= 24'(ev);
    settle();
  endtask

  task automatic pulse(input logic [5:0] h);
    @(posedge clk_i);
    host <= astl_pkg::astl_host_t'(h);
    @(posedge clk_i);
    host <= '0;
    settle();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(77583));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check(offset, 0);
    check(lim_p, 0);
    check(lim_m, 0);
    check(alarm, 0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? REV - 1 : int'($urandom % REV);
      e = int'($urandom % 2001) - 1000;
      @(posedge clk_i);
      flip <= 1'($urandom % 2);
      phys <= 22'(r);
      err <= 24'(e);
      settle();
      pulse(6'h30);
      off = (r + e + REV) % REV;
      u = exp_user(r, off, flip);
      check(offset, off);
      check(user_pos, u);
      check(cmd_pos, 0);
      check(fb_pos, (r + REV - off) % REV);
      check(deg, (64'(u) * 225) >> 14);
      put((r + 777) % REV, 0);
      pulse(6'h10);
      check(offset, off);
    end
    $display("test zero here done");
    @(posedge clk_i);
    flip <= 1'b0;
    restore <= 1'b1;
    @(posedge clk_i);
    restore <= 1'b0;
    settle();
    check(offset, 0);
    @(posedge clk_i);
    limit_data <= 22'h0003E8;
    pulse(6'h22);
    check(lim_p, 1000);
    put(2000, 0);
    pulse(6'h24);
    check(lim_m, 2000);
    $display("test limit load done");
    put(1500, 0);
    check(alarm, 4'hE);
    check(alarm_code, 8'hF2);
    check({allow_cw, allow_ccw}, 2'h1);
    put(1900, 0);
    check({allow_cw, allow_ccw}, 2'h2);
    @(posedge clk_i);
    down_req <= 1'b1;
    servo_on <= 1'b1;
    settle();
    check(halt, 1);
    check(alarm, 4'hF);
    @(posedge clk_i);
    down_req <= 1'b0;
    put(500, 0);
    check(alarm, 0);
    check(alarm_code, 8'h00);
    put(1500, -600);
    check(alarm, 0);
    $display("test overtravel done");
    @(posedge clk_i);
    servo_on <= 1'b0;
    flip <= 1'b1;
    put(REV - 1900, 0);
    check({allow_cw, allow_ccw}, 2'h1);
    put(REV - 500, 0);
    @(posedge clk_i);
    hw_plus <= 1'b1;
    settle();
    check({allow_cw, allow_ccw}, 2'h1);
    @(posedge clk_i);
    hw_plus <= 1'b0;
    hw_minus <= 1'b1;
    settle();
    check({allow_cw, allow_ccw}, 2'h2);
    $display("test direction done");
    @(posedge clk_i);
    hw_minus <= 1'b0;
    flip <= 1'b0;
    target <= 22'h000BB8;
    put(0, 0);
    check(path_up, 0);
    @(posedge clk_i);
    target <= 22'h0001F4;
    settle();
    check(path_up, 1);
    @(posedge clk_i);
    limit_data <= 22'h0007D0;
    pulse(6'h22);
    put(2000, 0);
    check(alarm, 0);
    $display("test path and equal limits done");
    test_done();
  end
endmodule
